// *** hdl/capture_timer_pkg.sv ***
package capture_timer_pkg;

    // Register-file addresses of the two control registers.
    localparam logic [7:0] TIMER0_CONTROL_ADDR = 8'hD2;
    localparam logic [7:0] TIMER1_CONTROL_ADDR = 8'hF5;
    localparam logic [7:0] CONTROL_RESET = 8'h00;

    // Field positions of the first control register.
    localparam int T0_CLK_SEL_BIT = 7;
    localparam int T0_PRESCALE_LO = 5;
    localparam int T0_EDGE_BIT = 4;
    localparam int T0_CLEAR_BIT = 3;
    localparam int T0_OVF_EN_BIT = 2;
    localparam int T0_CAP_EN_BIT = 1;
    localparam int T0_INPUT_SEL_BIT = 0;

    // Field positions of the second control register.
    localparam int T1_SOURCE_BIT = 7;
    localparam int T1_EDGE_BIT = 6;
    localparam int T1_CAP_EN_BIT = 5;
    localparam int T1_PENDING_BIT = 4;
    localparam int T1_CLEAR_BIT = 3;
    localparam int T1_OVF_EN_BIT = 2;
    localparam int T1_CLK_SEL_LO = 0;

    // Oscillator divide ratios, each as a terminal count of a free divider.
    localparam logic [8:0] DIV2_LAST = 9'h001;
    localparam logic [8:0] DIV8_LAST = 9'h007;
    localparam logic [8:0] DIV128_LAST = 9'h07F;
    localparam logic [8:0] DIV512_LAST = 9'h1FF;

    localparam logic [7:0] COUNT_ALL_ONES = 8'hFF;
    localparam logic [7:0] COUNT_ZERO = 8'h00;

endpackage : capture_timer_pkg

// *** hdl/capture_timer_channel.sv ***
module capture_timer_channel
    import capture_timer_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // Control
    input wire logic count_tick_i,
    input wire logic clear_i,
    input wire logic capture_edge_i,
    // Status
    output logic [7:0] counter_o,
    output logic [7:0] captured_o,
    output logic overflow_o,
    output logic capture_o
);

    logic [7:0] counter_reg;
    logic [7:0] captured_reg;
    logic overflow_reg;
    logic capture_reg;
    wire wrap = count_tick_i && (counter_reg == COUNT_ALL_ONES);

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            counter_reg <= COUNT_ZERO;
            captured_reg <= COUNT_ZERO;
            overflow_reg <= 1'b0;
            capture_reg <= 1'b0;
        end else begin
            if (clear_i) begin
                counter_reg <= COUNT_ZERO;
            end else if (count_tick_i) begin
                counter_reg <= counter_reg + 8'h01;
            end
            if (capture_edge_i) begin
                captured_reg <= counter_reg;
            end
            overflow_reg <= wrap && !clear_i;
            capture_reg <= capture_edge_i;
        end
    end

    assign counter_o = counter_reg;
    assign captured_o = captured_reg;
    assign overflow_o = overflow_reg;
    assign capture_o = capture_reg;

endmodule // capture_timer_channel

// *** hdl/dual_capture_timer_control.sv ***
// Contract
// - Timer 0 clock is osc/128 or osc/8, then prescaled by 1 to 4.
// - Writing one to timer 0 clear bit zeroes its counter; zero does nothing.
// - No timer 0 overflow interrupt while the count stands at all ones.
// - Timer 0 overflow interrupt when the count moves from all ones to zero.
// - At count zero, overflow is signalled before any capture interrupt.
// - Timer 0 overflow still works with its capture interrupt disabled.
// - Timer 1 trigger: interval signal when source bit zero, vertical sync when one.
// - Timer 1 vertical sync edge: zero rising, one falling.
// - Timer 1 capture interrupt passes only while its enable is one.
// - Timer 1 pending bit reads one while a capture is pending.
// - Writing zero clears timer 1 pending bit; writing one leaves it.
// - Writing one to timer 1 clear bit resets its counter; zero does nothing.
// - Timer 1 overflow interrupt passes only while its enable is one.
// - Timer 1 clock: 00 sync, 01 osc/2, 10 osc/128, 11 osc/512.
// - Reset loads zero into both control registers.
module dual_capture_timer_control
    import capture_timer_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // CPU register file access
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_write_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // External and on-chip event sources
    input wire logic capture_pin_i,
    input wire logic vsync_out_i,
    input wire logic hsync_count_i,
    input wire logic interval_tick_i,
    // Counter and capture values
    output logic [7:0] timer0_counter_o,
    output logic [7:0] timer0_captured_o,
    output logic [7:0] timer1_counter_o,
    output logic [7:0] timer1_captured_o,
    // Interrupt requests
    output logic timer0_capture_irq_o,
    output logic timer0_overflow_irq_o,
    output logic timer1_capture_irq_o,
    output logic timer1_overflow_irq_o
);

    ////////////////////////////////////////////////////////////////////////////

    logic [7:0] capture_timer0_control_reg;
    logic [7:0] capture_timer1_control_reg;
    logic timer1_capture_pending_reg;
    logic [8:0] osc_div_reg;
    logic [1:0] prescale_reg;
    logic pin_prev_reg;
    logic vsync_prev_reg;
    logic hsync_prev_reg;
    logic t0_cap_defer_reg;

    wire write0 = reg_write_i && (reg_addr_i == TIMER0_CONTROL_ADDR);
    wire write1 = reg_write_i && (reg_addr_i == TIMER1_CONTROL_ADDR);

    function automatic logic div_hit(input logic [8:0] cnt, input logic [8:0] last);
        div_hit = ((cnt & last) == last);
    endfunction

    function automatic logic edge_seen(input logic prev, input logic cur, input logic fall);
        edge_seen = fall ? (prev && !cur) : (!prev && cur);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Timer 0 clocking and capture selection.

    wire t0_base_tick = capture_timer0_control_reg[T0_CLK_SEL_BIT]
        ? div_hit(osc_div_reg, DIV8_LAST) : div_hit(osc_div_reg, DIV128_LAST);
    wire [1:0] t0_prescale = capture_timer0_control_reg[T0_PRESCALE_LO +: 2];
    wire t0_tick = t0_base_tick && (prescale_reg == t0_prescale);
    wire t0_cap_src = capture_timer0_control_reg[T0_INPUT_SEL_BIT] ? vsync_out_i
        : capture_pin_i;
    wire t0_cap_prev = capture_timer0_control_reg[T0_INPUT_SEL_BIT] ? vsync_prev_reg
        : pin_prev_reg;
    wire t0_cap_edge = edge_seen(t0_cap_prev, t0_cap_src,
        capture_timer0_control_reg[T0_EDGE_BIT]);
    wire t0_clear = write0 && reg_wdata_i[T0_CLEAR_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // Timer 1 clocking and capture selection.

    wire [1:0] t1_clk_sel = capture_timer1_control_reg[T1_CLK_SEL_LO +: 2];
    wire hsync_rise = !hsync_prev_reg && hsync_count_i;
    wire t1_tick = (t1_clk_sel == 2'b00) ? hsync_rise
        : (t1_clk_sel == 2'b01) ? div_hit(osc_div_reg, DIV2_LAST)
        : (t1_clk_sel == 2'b10) ? div_hit(osc_div_reg, DIV128_LAST)
        : div_hit(osc_div_reg, DIV512_LAST);
    wire vsync_edge1 = edge_seen(vsync_prev_reg, vsync_out_i,
        capture_timer1_control_reg[T1_EDGE_BIT]);
    wire t1_cap_edge = capture_timer1_control_reg[T1_SOURCE_BIT] ? vsync_edge1
        : interval_tick_i;
    wire t1_clear = write1 && reg_wdata_i[T1_CLEAR_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // Counter channels.

    logic t0_overflow;
    logic t0_capture;
    logic t1_overflow;
    logic t1_capture;

    capture_timer_channel u_timer0 (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .count_tick_i(t0_tick),
        .clear_i(t0_clear),
        .capture_edge_i(t0_cap_edge),
        .counter_o(timer0_counter_o),
        .captured_o(timer0_captured_o),
        .overflow_o(t0_overflow),
        .capture_o(t0_capture)
    );

    capture_timer_channel u_timer1 (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .count_tick_i(t1_tick),
        .clear_i(t1_clear),
        .capture_edge_i(t1_cap_edge),
        .counter_o(timer1_counter_o),
        .captured_o(timer1_captured_o),
        .overflow_o(t1_overflow),
        .capture_o(t1_capture)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Control registers and timing state.

    // Clear bits are write-only strobes; the stored bit always reads zero.
    wire [7:0] ctrl0_next = reg_wdata_i & ~(8'h01 << T0_CLEAR_BIT);
    wire [7:0] ctrl1_next = reg_wdata_i & ~(8'h01 << T1_CLEAR_BIT) & ~(8'h01 << T1_PENDING_BIT);
    wire t1_pend_set = t1_capture;
    wire t1_pend_clr = write1 && !reg_wdata_i[T1_PENDING_BIT];
    wire [1:0] prescale_next = (prescale_reg == t0_prescale) ? 2'b00 : prescale_reg + 2'b01;

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            capture_timer0_control_reg <= CONTROL_RESET;
            capture_timer1_control_reg <= CONTROL_RESET;
            timer1_capture_pending_reg <= 1'b0;
            osc_div_reg <= 9'h000;
            prescale_reg <= 2'b00;
            pin_prev_reg <= 1'b0;
            vsync_prev_reg <= 1'b0;
            hsync_prev_reg <= 1'b0;
            t0_cap_defer_reg <= 1'b0;
        end else begin
            if (write0) begin
                capture_timer0_control_reg <= ctrl0_next;
            end
            if (write1) begin
                capture_timer1_control_reg <= ctrl1_next;
            end
            // A capture arriving with the clear wins.
            if (t1_pend_set) begin
                timer1_capture_pending_reg <= 1'b1;
            end else if (t1_pend_clr) begin
                timer1_capture_pending_reg <= 1'b0;
            end
            osc_div_reg <= osc_div_reg + 9'h001;
            if (t0_base_tick) begin
                prescale_reg <= prescale_next;
            end
            pin_prev_reg <= capture_pin_i;
            vsync_prev_reg <= vsync_out_i;
            hsync_prev_reg <= hsync_count_i;
            // A capture that lands with a wrap is delayed one cycle.
            t0_cap_defer_reg <= t0_capture && t0_overflow;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt requests and read data.

    // Overflow only on the all-ones to zero wrap, independent of capture enable.
    wire t0_ovf_req = t0_overflow;
    wire t0_cap_req = (t0_capture && !t0_overflow) || t0_cap_defer_reg;

    assign timer0_overflow_irq_o = t0_ovf_req
        && capture_timer0_control_reg[T0_OVF_EN_BIT];
    assign timer0_capture_irq_o = t0_cap_req
        && capture_timer0_control_reg[T0_CAP_EN_BIT];
    assign timer1_capture_irq_o = timer1_capture_pending_reg
        && capture_timer1_control_reg[T1_CAP_EN_BIT];
    assign timer1_overflow_irq_o = t1_overflow
        && capture_timer1_control_reg[T1_OVF_EN_BIT];

    wire [7:0] ctrl1_read = capture_timer1_control_reg
        | ({7'h00, timer1_capture_pending_reg} << T1_PENDING_BIT);

    assign reg_rdata_o = (reg_addr_i == TIMER0_CONTROL_ADDR) ? capture_timer0_control_reg
        : (reg_addr_i == TIMER1_CONTROL_ADDR) ? ctrl1_read : 8'h00;

endmodule // dual_capture_timer_control

// *** sim/dual_capture_timer_control_sva.sv ***
module dual_capture_timer_control_sva
    import capture_timer_pkg::*;
(
    // Clock, reset, register writes and interval tick
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_write_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic interval_tick_i,
    // Observed outputs
    input wire logic [7:0] timer0_counter_o,
    input wire logic [7:0] timer1_counter_o,
    input wire logic timer0_capture_irq_o,
    input wire logic timer0_overflow_irq_o,
    input wire logic timer1_capture_irq_o,
    input wire logic timer1_overflow_irq_o
);
    logic [7:0] ctl0_reg;
    logic [7:0] ctl1_reg;
    logic wr0;
    logic wr1;
    logic clr0;
    assign wr0 = reg_write_i && (reg_addr_i == TIMER0_CONTROL_ADDR);
    assign wr1 = reg_write_i && (reg_addr_i == TIMER1_CONTROL_ADDR);
    assign clr0 = wr0 && reg_wdata_i[T0_CLEAR_BIT];
    // Shadow copies of the control bits, written when the design takes a write.
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            ctl0_reg <= CONTROL_RESET;
            ctl1_reg <= CONTROL_RESET;
        end else begin
            ctl0_reg <= wr0 ? reg_wdata_i : ctl0_reg;
            ctl1_reg <= wr1 ? reg_wdata_i : ctl1_reg;
        end
    end
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    ovf0_gate_a: assert property (timer0_overflow_irq_o |-> ctl0_reg[T0_OVF_EN_BIT])
        else $error("timer0 overflow pulse while disabled");
    cap0_gate_a: assert property (timer0_capture_irq_o |-> ctl0_reg[T0_CAP_EN_BIT])
        else $error("timer0 capture pulse while disabled");
    ovf0_wrap_a: assert property (
        timer0_overflow_irq_o |-> $past(timer0_counter_o, 2) == COUNT_ALL_ONES)
        else $error("timer0 overflow without a wrap");
    ovf0_fire_a: assert property (
        $past(timer0_counter_o) == COUNT_ALL_ONES && timer0_counter_o == COUNT_ZERO
        && !$past(clr0) && ctl0_reg[T0_OVF_EN_BIT] |-> timer0_overflow_irq_o)
        else $error("timer0 wrap gave no overflow pulse");
    clear0_zero_a: assert property (clr0 |=> timer0_counter_o == COUNT_ZERO)
        else $error("timer0 counter not cleared");
    clear1_zero_a: assert property (
        wr1 && reg_wdata_i[T1_CLEAR_BIT] |=> timer1_counter_o == COUNT_ZERO)
        else $error("timer1 counter not cleared");
    tick0_spacing_a: assert property (
        timer0_counter_o == $past(timer0_counter_o) + 8'h01 && !$past(clr0) |=>
        (timer0_counter_o == $past(timer0_counter_o) || timer0_counter_o == 8'h00) [*7])
        else $error("timer0 counted faster than the base clock");
    cap1_gate_a: assert property (timer1_capture_irq_o |-> ctl1_reg[T1_CAP_EN_BIT])
        else $error("timer1 capture request while disabled");
    ovf1_gate_a: assert property (timer1_overflow_irq_o |-> ctl1_reg[T1_OVF_EN_BIT])
        else $error("timer1 overflow pulse while disabled");
    trig1_capture_a: assert property (
        interval_tick_i && !ctl1_reg[T1_SOURCE_BIT] && ctl1_reg[T1_CAP_EN_BIT]
        |-> ##[1:3] timer1_capture_irq_o)
        else $error("interval tick gave no timer1 capture");
endmodule // dual_capture_timer_control_sva

bind dual_capture_timer_control dual_capture_timer_control_sva u_sva (.core_clk_i, .reset_i,
    .reg_addr_i, .reg_write_i, .reg_wdata_i, .interval_tick_i, .timer0_counter_o,
    .timer1_counter_o, .timer0_capture_irq_o, .timer0_overflow_irq_o, .timer1_capture_irq_o,
    .timer1_overflow_irq_o);

// *** sim/sync_source_model.sv ***
module sync_source_model (
    // Clock, reset and bench commands
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic vsync_cmd_i,
    input wire logic interval_req_i,
    // Sync processor outputs
    output logic vsync_out_o,
    output logic hsync_o,
    output logic interval_tick_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Horizontal sync runs free with a period of twice this many clocks.
    localparam int HSYNC_HALF = 5;
    int phase;
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            vsync_out_o <= 1'b0;
            hsync_o <= 1'b0;
            interval_tick_o <= 1'b0;
            phase <= 0;
        end else begin
            vsync_out_o <= vsync_cmd_i;
            interval_tick_o <= interval_req_i;
            phase <= (phase == HSYNC_HALF - 1) ? 0 : phase + 1;
            hsync_o <= (phase == HSYNC_HALF - 1) ? !hsync_o : hsync_o;
        end
    end
endmodule // sync_source_model

// *** sim/test_dual_capture_timer_control.sv ***
module test_dual_capture_timer_control
    import capture_timer_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] r; int p;} row_s;
    logic core_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [7:0] reg_addr_i = 8'h00;
    logic reg_write_i = 1'b0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic capture_pin_i = 1'b0;
    logic vsync_cmd = 1'b0;
    logic interval_req = 1'b0;
    logic [7:0] reg_rdata_o, timer0_counter_o, timer1_counter_o;
    logic [7:0] timer0_captured_o, timer1_captured_o;
    logic vsync_out_i, hsync_count_i, interval_tick_i;
    wire logic [3:0] irqs;
    int n_mismatch = 0;
    int n_tests = 0;
    int c;
    row_s rows[11] = '{'{8'hD2, 8'hFF, 8'hF7, 0}, '{8'hD2, 8'h80, 8'h80, 8},
        '{8'hD2, 8'hA0, 8'hA0, 16},
        '{8'hD2, 8'hE0, 8'hE0, 32}, '{8'hD2, 8'h40, 8'h40, 384}, '{8'hF5, 8'h01, 8'h01, 2},
        '{8'hF5, 8'h02, 8'h02, 128}, '{8'hF5, 8'h03, 8'h03, 512}, '{8'hF5, 8'h00, 8'h00, 10},
        '{8'hF5, 8'hDF, 8'hC7, 0}, '{8'h10, 8'h5A, 8'h00, 0}};
    logic [10:0] caps[5] = '{{8'h82, 3'b101}, {8'h92, 3'b001}, {8'h83, 3'b011},
        {8'h93, 3'b001}, {8'h80, 3'b100}};
    ////////////////////////////////////////////////////////////////////////////////
    dual_capture_timer_control u_dut (.core_clk_i, .reset_i, .reg_addr_i, .reg_write_i,
        .reg_wdata_i, .reg_rdata_o, .capture_pin_i, .vsync_out_i, .hsync_count_i,
        .interval_tick_i, .timer0_counter_o, .timer0_captured_o, .timer1_counter_o,
        .timer1_captured_o, .timer0_capture_irq_o(irqs[0]), .timer0_overflow_irq_o(irqs[1]),
        .timer1_capture_irq_o(irqs[2]), .timer1_overflow_irq_o(irqs[3]));
    sync_source_model u_sync (.core_clk_i, .reset_i, .vsync_cmd_i(vsync_cmd),
        .interval_req_i(interval_req), .vsync_out_o(vsync_out_i), .hsync_o(hsync_count_i),
        .interval_tick_o(interval_tick_i));
    initial begin
        forever #2 core_clk_i = !core_clk_i;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_write_i <= 1'b1;
        @(posedge core_clk_i);
        reg_write_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] v);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        #1 v = {8'h00, reg_rdata_o};
    endtask
    task automatic count(input int w, input int n, output int k);
        k = 0;
        repeat (n) begin
            @(posedge core_clk_i);
            #1 k += int'(irqs[w] !== 1'b0);
        end
    endtask
    // The first pass only finds a tick edge; the second measures one full period.
    task automatic period(input int w, output int p);
        logic [7:0] v;
        repeat (2) begin
            v = w ? timer1_counter_o : timer0_counter_o;
            p = 0;
            while ((w ? timer1_counter_o : timer0_counter_o) === v && p < 1100) begin
                @(posedge core_clk_i);
                #1 p++;
            end
        end
    endtask
    task automatic close_out;
        $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (40000) @(posedge core_clk_i);
        n_mismatch++;
        close_out();
    end
    initial begin
        logic [15:0] v;
        repeat (20) @(posedge core_clk_i);
        reset_i <= 1'b0;
        rd(8'hD2, v); check(v, 16'h0000);
        rd(8'hF5, v); check(v, 16'h0000);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, v); check(v, {8'h00, rows[i].r});
            if (rows[i].p > 0) begin
                period(rows[i].a == 8'hF5, c); check(c, rows[i].p);
            end
        end
        wr(8'hD2, 8'h84); count(1, 2048, c); check(c, 1);
        wr(8'hD2, 8'h80); count(1, 2048, c); check(c, 0);
        wr(8'hD2, 8'h8C); #1 check(timer0_counter_o, 0);
        foreach (caps[i]) begin
            wr(8'hD2, caps[i][10:3]);
            capture_pin_i <= caps[i][2];
            vsync_cmd <= caps[i][1];
            count(0, 8, c); check(c, caps[i][0]);
        end
        wr(8'hD2, 8'h7A); #1 check(timer0_counter_o, 16'h0000);
        period(0, c); check(c, 512);
        @(posedge core_clk_i);
        capture_pin_i <= 1'b0;
        count(0, 8, c); check(c, 1);
        check(timer0_captured_o, 16'h0002);
        wr(8'hF5, 8'h20);
        interval_req <= 1'b1;
        @(posedge core_clk_i);
        interval_req <= 1'b0;
        count(2, 3, c);
        rd(8'hF5, v); check(v, 16'h0030);
        check(irqs[2], 1);
        wr(8'hF5, 8'h30); rd(8'hF5, v); check(v, 16'h0030);
        wr(8'hF5, 8'h10); #1 check(irqs[2], 0);
        wr(8'hF5, 8'h20); rd(8'hF5, v); check(v, 16'h0020);
        wr(8'hF5, 8'hEB); #1 check(timer1_counter_o, 16'h0000);
        period(1, c); check(c, 512);
        @(posedge core_clk_i);
        vsync_cmd <= 1'b1;
        count(2, 4, c); rd(8'hF5, v); check(v, 16'h00E3);
        @(posedge core_clk_i);
        vsync_cmd <= 1'b0;
        count(2, 4, c); rd(8'hF5, v); check(v, 16'h00F3);
        check(timer1_captured_o, 16'h0002);
        wr(8'hF5, 8'hA0);
        vsync_cmd <= 1'b1;
        count(2, 4, c); rd(8'hF5, v); check(v, 16'h00B0);
        wr(8'hF5, 8'h05); count(3, 512, c); check(c, 1);
        wr(8'hF5, 8'h01); count(3, 512, c); check(c, 0);
        close_out();
    end
endmodule // test_dual_capture_timer_control
